// ===== rtl/sptx_pkg.sv
package sptx_pkg;

  // Serial input formats; the first value is the one taken after reset
  typedef enum logic [1:0] {
    SPTX_FMT_I2S,
    SPTX_FMT_LJ,
    SPTX_FMT_RJ
  } sptx_fmt_type;

  // Word widths, in the order of their configuration codes
  typedef enum logic [1:0] {
    SPTX_W16,
    SPTX_W18,
    SPTX_W20,
    SPTX_W24
  } sptx_width_type;

  // Configuration codes seen on the format input
  localparam logic [1:0] SPTX_FMT_CODE_LJ = 2'h1;
  localparam logic [1:0] SPTX_FMT_CODE_RJ = 2'h2;

  // Sample and word layout
  localparam int unsigned SPTX_SAMPLE_BITS = 24;
  localparam int unsigned SPTX_WORD_BITS = SPTX_SAMPLE_BITS + 1;
  localparam int unsigned SPTX_FIFO_DEPTH = 32;
  localparam int unsigned SPTX_POS_BITS = 6;

  // Bit positions counted in serial clocks from the frame sync edge
  localparam logic [5:0] SPTX_POS_MAX = 6'h3f;
  localparam logic [5:0] SPTX_POS_ONE = 6'h01;
  localparam logic [5:0] SPTX_HALF_FRAME = 6'h20;
  localparam logic [5:0] SPTX_LJ_DELAY = 6'h00;
  localparam logic [5:0] SPTX_I2S_DELAY = 6'h01;
  localparam logic [5:0] SPTX_BITS_16 = 6'h10;
  localparam logic [5:0] SPTX_BITS_18 = 6'h12;
  localparam logic [5:0] SPTX_BITS_20 = 6'h14;
  localparam logic [5:0] SPTX_BITS_24 = 6'h18;

  // Reset choice for the word width
  localparam sptx_width_type SPTX_WIDTH_RESET = SPTX_W24;

  // Number of data bits in one word
  function automatic logic [5:0] sptx_word_bits(input sptx_width_type w);
    case (w)
      SPTX_W16: sptx_word_bits = SPTX_BITS_16;
      SPTX_W18: sptx_word_bits = SPTX_BITS_18;
      SPTX_W20: sptx_word_bits = SPTX_BITS_20;
      default: sptx_word_bits = SPTX_BITS_24;
    endcase
  endfunction

  // Position of the MSB after the frame sync edge
  function automatic logic [5:0] sptx_first_pos(input sptx_fmt_type f, input sptx_width_type w);
    case (f)
      SPTX_FMT_LJ: sptx_first_pos = SPTX_LJ_DELAY;
      SPTX_FMT_RJ: sptx_first_pos = SPTX_HALF_FRAME - sptx_word_bits(w);
      default: sptx_first_pos = SPTX_I2S_DELAY;
    endcase
  endfunction

  // Channel from frame sync level; I2S runs with the opposite polarity
  function automatic logic sptx_is_right(input sptx_fmt_type f, input logic fs);
    if (f == SPTX_FMT_I2S) begin
      sptx_is_right = fs;
    end else begin
      sptx_is_right = ~fs;
    end
  endfunction

endpackage

// ===== rtl/sptx_stream_if.sv
`timescale 1ns/1ps
interface sptx_stream_if #(
  parameter int WIDTH = 25
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface // sptx_stream_if

// ===== rtl/sptx_fifo.sv
`timescale 1ns/1ps
module sptx_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 32
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  sptx_stream_if.snk s_in,
  sptx_stream_if.src s_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  logic full;
  logic empty;
  logic push;
  logic pop;

  // Full when pointers differ only in the wrap bit
  assign full = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign empty = (wr_ptr_q == rd_ptr_q);
  assign s_in.ready = ~full;
  assign s_out.valid = ~empty;
  assign s_out.data = mem[rd_ptr_q[AW-1:0]];
  assign push = s_in.valid && ~full;
  assign pop = s_out.ready && ~empty;

  // Storage; no reset needed, empty flag guards stale words
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_q[AW-1:0]] <= s_in.data;
    end
  end

  // Pointers
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

  property p_full_holds_wr;
    @(posedge i_clk) disable iff (!i_reset_n)
    (full && s_in.valid) |=> (wr_ptr_q == $past(wr_ptr_q));
  endproperty
  a_full_holds_wr: assert property (p_full_holds_wr) else $error("fifo written while full");

  property p_pop_advances;
    @(posedge i_clk) disable iff (!i_reset_n)
    (s_out.ready && !empty) |=> (rd_ptr_q == $past(rd_ptr_q) + 1'b1);
  endproperty
  a_pop_advances: assert property (p_pop_advances) else $error("fifo read pointer stuck");

  property p_fills;
    @(posedge i_clk) disable iff (!i_reset_n) full;
  endproperty
  c_fills: cover property (p_fills);
endmodule // sptx_fifo

// ===== rtl/sptx_serial_in.sv
`timescale 1ns/1ps
// What this block does
// - Accepts left-justified, I2S or right-justified words of 16, 18, 20 or 24 bits.
// - Right-justified: frame sync high means left word, low means right word.
// - Data and frame sync are captured on the rising serial clock edge.
// - Right-justified MSB comes 16, 14, 12 or 8 clocks after sync edge.
// - Right-justified assumes 64 clocks per frame; LSB ends at next sync edge.
// - I2S: frame sync low means left word, high means right word.
// - Input format is I2S after reset until another one is configured.
// - I2S MSB starts one serial clock after each frame sync edge.
// - Left-justified: sync high is left, MSB lands on the sync edge itself.
module sptx_serial_in import sptx_pkg::*; (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_sclk,
  input wire logic i_fsync,
  input wire logic i_sdata,
  input wire logic i_cfg_we,
  input wire logic [1:0] i_cfg_fmt,
  input wire logic [1:0] i_cfg_width,
  input wire logic i_ready,
  output logic o_valid,
  output logic [SPTX_SAMPLE_BITS-1:0] o_data,
  output logic o_right,
  output logic o_overflow
);
  // System clock domain: configuration
  sptx_fmt_type cfg_fmt_q;
  sptx_width_type cfg_width_q;

  function automatic sptx_fmt_type fmt_decode(input logic [1:0] code);
    case (code)
      SPTX_FMT_CODE_LJ: fmt_decode = SPTX_FMT_LJ;
      SPTX_FMT_CODE_RJ: fmt_decode = SPTX_FMT_RJ;
      default: fmt_decode = SPTX_FMT_I2S;
    endcase
  endfunction

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      cfg_fmt_q <= SPTX_FMT_I2S;
      cfg_width_q <= SPTX_WIDTH_RESET;
    end else if (i_cfg_we) begin
      cfg_fmt_q <= fmt_decode(i_cfg_fmt);
      cfg_width_q <= sptx_width_type'(i_cfg_width);
    end
  end

  // Serial clock domain
  logic lrst_meta_q;
  logic lrst_n_q;
  logic [3:0] cfg_meta_q;
  logic [3:0] cfg_lk_q;
  sptx_fmt_type lk_fmt;
  sptx_width_type lk_width;

  // Reset into the link domain; only takes effect while the serial clock runs
  always_ff @(posedge i_sclk) begin
    lrst_meta_q <= i_reset_n;
    lrst_n_q <= lrst_meta_q;
  end

  // Config is quasi-static: change it only between streams, bits may skew
  always_ff @(posedge i_sclk) begin
    cfg_meta_q <= {cfg_fmt_q, cfg_width_q};
    cfg_lk_q <= cfg_meta_q;
  end

  assign lk_fmt = sptx_fmt_type'(cfg_lk_q[3:2]);
  assign lk_width = sptx_width_type'(cfg_lk_q[1:0]);

  logic fs_q;
  logic trans;
  logic [SPTX_POS_BITS-1:0] cnt_q;
  logic [SPTX_POS_BITS-1:0] pos_d;
  logic [SPTX_POS_BITS-1:0] first_pos;
  logic [SPTX_POS_BITS-1:0] last_pos;
  logic in_win;
  logic right_q;
  logic right_d;
  logic done_d;
  logic done_q;
  logic [SPTX_SAMPLE_BITS-1:0] shreg_q;
  logic [SPTX_SAMPLE_BITS-1:0] shreg_d;
  logic [SPTX_SAMPLE_BITS-1:0] hold_data_q;
  logic hold_right_q;
  logic tog_q;

  // sync edge seen on rising clock
  assign trans = (i_fsync != fs_q);

  // restart at every sync edge, saturate past the frame
  always_comb begin
    if (trans) begin
      pos_d = '0;
    end else if (cnt_q == SPTX_POS_MAX) begin
      pos_d = cnt_q;
    end else begin
      pos_d = cnt_q + SPTX_POS_ONE;
    end
  end

  assign first_pos = sptx_first_pos(lk_fmt, lk_width);
  assign last_pos = first_pos + sptx_word_bits(lk_width) - SPTX_POS_ONE;
  assign in_win = (pos_d >= first_pos) && (pos_d <= last_pos);
  assign done_d = in_win && (pos_d == last_pos);
  assign shreg_d = {shreg_q[SPTX_SAMPLE_BITS-2:0], i_sdata};

  assign right_d = trans ? sptx_is_right(lk_fmt, i_fsync) : right_q;

  // Left-align a finished word into the 24-bit sample
  function automatic logic [SPTX_SAMPLE_BITS-1:0] align(input logic [SPTX_SAMPLE_BITS-1:0] d,
                                                        input sptx_width_type w);
    case (w)
      SPTX_W16: align = {d[15:0], 8'h00};
      SPTX_W18: align = {d[17:0], 6'h00};
      SPTX_W20: align = {d[19:0], 4'h0};
      default: align = d;
    endcase
  endfunction

  always_ff @(posedge i_sclk) begin
    if (!lrst_n_q) begin
      fs_q <= 1'b0;
      cnt_q <= SPTX_POS_MAX;
      right_q <= 1'b0;
    end else begin
      fs_q <= i_fsync;
      cnt_q <= pos_d;
      right_q <= right_d;
    end
  end

  // shift in data only inside the word
  always_ff @(posedge i_sclk) begin
    if (!lrst_n_q) begin
      shreg_q <= '0;
    end else if (in_win) begin
      shreg_q <= shreg_d;
    end
  end

  always_ff @(posedge i_sclk) begin
    if (!lrst_n_q) begin
      done_q <= 1'b0;
      hold_data_q <= '0;
      hold_right_q <= 1'b0;
      tog_q <= 1'b0;
    end else begin
      done_q <= done_d;
      if (done_d) begin
        hold_data_q <= align(shreg_d, lk_width);
        hold_right_q <= right_d;
        tog_q <= ~tog_q;
      end
    end
  end

  // Back in the system clock domain
  logic [2:0] tsync_q;
  logic tog_edge;
  logic pend_q;
  logic [SPTX_WORD_BITS-1:0] pend_data_q;
  logic overflow_q;

  sptx_stream_if #(.WIDTH(SPTX_WORD_BITS)) in_if ();
  sptx_stream_if #(.WIDTH(SPTX_WORD_BITS)) out_if ();

  // Toggle crossing; held word is stable for many system clocks after it
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      tsync_q <= '0;
    end else begin
      tsync_q <= {tsync_q[1:0], tog_q};
    end
  end
  assign tog_edge = tsync_q[2] ^ tsync_q[1];

  // Staging word; stalls on a full FIFO, a second arrival overwrites it
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      pend_q <= 1'b0;
    end else if (tog_edge) begin
      pend_q <= 1'b1;
    end else if (in_if.ready) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      pend_data_q <= '0;
    end else if (tog_edge) begin
      pend_data_q <= {hold_right_q, hold_data_q};
    end
  end

  // Lost word flag; the serial source cannot be paused
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      overflow_q <= 1'b0;
    end else begin
      overflow_q <= tog_edge && pend_q && !in_if.ready;
    end
  end

  assign in_if.valid = pend_q;
  assign in_if.data = pend_data_q;

  sptx_fifo #(
    .WIDTH(SPTX_WORD_BITS),
    .DEPTH(SPTX_FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .s_in(in_if),
    .s_out(out_if)
  );

  // User side
  assign out_if.ready = i_ready;
  assign o_valid = out_if.valid;
  assign o_data = out_if.data[SPTX_SAMPLE_BITS-1:0];
  assign o_right = out_if.data[SPTX_WORD_BITS-1];
  assign o_overflow = overflow_q;

  // Checks
  property p_default_i2s;
    @(posedge i_clk) disable iff (1'b0)
    (!i_reset_n ##1 (i_reset_n && !i_cfg_we)) |-> (cfg_fmt_q == SPTX_FMT_I2S);
  endproperty
  a_default_i2s: assert property (p_default_i2s) else $error("format not I2S after reset");

  property p_restart;
    @(posedge i_sclk) disable iff (!lrst_n_q)
    (trans ##1 (!trans)[*2]) |=> (cnt_q == 6'h02);
  endproperty
  a_restart: assert property (p_restart) else $error("bit counter not restarted");

  property p_lj16_end;
    @(posedge i_sclk) disable iff (!lrst_n_q)
    (done_q && lk_fmt == SPTX_FMT_LJ && lk_width == SPTX_W16) |-> (cnt_q == 6'h0f);
  endproperty
  a_lj16_end: assert property (p_lj16_end) else $error("LJ 16-bit word ends wrong");

  property p_lj18_end;
    @(posedge i_sclk) disable iff (!lrst_n_q)
    (done_q && lk_fmt == SPTX_FMT_LJ && lk_width == SPTX_W18) |-> (cnt_q == 6'h11);
  endproperty
  a_lj18_end: assert property (p_lj18_end) else $error("LJ 18-bit word ends wrong");

  property p_i2s24_end;
    @(posedge i_sclk) disable iff (!lrst_n_q)
    (done_q && lk_fmt == SPTX_FMT_I2S && lk_width == SPTX_W24) |-> (cnt_q == 6'h18);
  endproperty
  a_i2s24_end: assert property (p_i2s24_end) else $error("I2S word ends wrong");

  property p_rj20_start;
    @(posedge i_sclk) disable iff (!lrst_n_q)
    (lk_fmt == SPTX_FMT_RJ && lk_width == SPTX_W20 && in_win && !$past(in_win))
      |-> (pos_d == 6'h0c);
  endproperty
  a_rj20_start: assert property (p_rj20_start) else $error("RJ MSB delay wrong");

  property p_rj_end;
    @(posedge i_sclk) disable iff (!lrst_n_q)
    (done_q && lk_fmt == SPTX_FMT_RJ) |-> (cnt_q == 6'h1f);
  endproperty
  a_rj_end: assert property (p_rj_end) else $error("RJ LSB not at frame end");

  property p_rj_chan;
    @(posedge i_sclk) disable iff (!lrst_n_q)
    (done_q && lk_fmt == SPTX_FMT_RJ && $stable(cnt_q[5])) |-> (hold_right_q == !fs_q);
  endproperty
  a_rj_chan: assert property (p_rj_chan) else $error("RJ channel polarity wrong");

  property p_i2s_chan;
    @(posedge i_sclk) disable iff (!lrst_n_q)
    (done_q && lk_fmt == SPTX_FMT_I2S) |-> (hold_right_q == fs_q);
  endproperty
  a_i2s_chan: assert property (p_i2s_chan) else $error("I2S channel polarity wrong");

  property p_cross;
    @(posedge i_clk) disable iff (!i_reset_n)
    tog_edge |=> (pend_q && pend_data_q == {$past(hold_right_q), $past(hold_data_q)});
  endproperty
  a_cross: assert property (p_cross) else $error("word lost at crossing");

  property p_cov_word;
    @(posedge i_clk) disable iff (!i_reset_n) o_valid && i_ready;
  endproperty
  c_cov_word: cover property (p_cov_word);

  property p_cov_rj;
    @(posedge i_sclk) disable iff (!lrst_n_q) done_q && lk_fmt == SPTX_FMT_RJ;
  endproperty
  c_cov_rj: cover property (p_cov_rj);

  property p_cov_ovf;
    @(posedge i_clk) disable iff (!i_reset_n) o_overflow;
  endproperty
  c_cov_ovf: cover property (p_cov_ovf);
endmodule // sptx_serial_in

// ===== bench/sptx_serial_src.sv
`timescale 1ns/1ps
// Upstream serial source: bit clock, frame sync and data, 80 ns bit period
module sptx_serial_src (
  output logic o_sclk,
  output logic o_fsync,
  output logic o_sdata
);
  initial begin
    o_sclk = 1'b0;
    o_fsync = 1'b0;
    o_sdata = 1'b0;
  end

  // Clocks with sync held; data flips so a stale bit is never mistaken for a good one
  task automatic idle(input int n);
    repeat (n) begin
      o_sdata = ~o_sdata;
      #40 o_sclk = 1'b1;
      #40 o_sclk = 1'b0;
    end
  endtask

  // One half frame of n clocks; clock rests low afterwards
  task automatic half(input logic fs, input logic [1:0] fmt, input int w,
                      input logic [23:0] word, input int n);
    int first;
    first = (fmt == 2'h1) ? 0 : (fmt == 2'h2) ? 32 - w : 1;
    // Set while low, valid at rise
    for (int p = 0; p < n; p++) begin
      o_fsync = fs;
      if (p >= first && p < first + w) o_sdata = word[w - 1 - (p - first)];
      else o_sdata = ~o_sdata;
      #40 o_sclk = 1'b1;
      #40 o_sclk = 1'b0;
    end
  endtask
endmodule // sptx_serial_src

// ===== bench/sptx_serial_in_tb.sv
`timescale 1ns/1ps
module sptx_serial_in_tb;
  import sptx_pkg::*;
  typedef struct {
    logic [1:0] fmt;
    logic [1:0] wc;
    logic [23:0] hi;
    logic [23:0] lo;
  } sptx_row_type;

  logic clk, rst_n, sclk, fsync, sdata, cfg_we, ready, valid, right, ovf;
  logic [1:0] cfg_fmt, cfg_width;
  logic [23:0] data;
  int fail_count = 0;
  int n_checks = 0;
  int ovf_seen = 0;
  // Each format and width code at least once, code 3 of format included
  sptx_row_type rows [7] = '{
    '{2'h0, 2'h0, 24'h00_a5c3, 24'h00_5a3c},
    '{2'h1, 2'h1, 24'h02_b1e7, 24'h01_4e18},
    '{2'h2, 2'h2, 24'h0c_9a53, 24'h03_65ac},
    '{2'h2, 2'h3, 24'h8c_3a51, 24'h73_c5ae},
    '{2'h3, 2'h2, 24'h0f_0f0f, 24'h00_f0f1},
    '{2'h2, 2'h0, 24'h00_8001, 24'h00_7ffe},
    '{2'h1, 2'h3, 24'hf0_0001, 24'h0f_fffe}
  };

  sptx_serial_in u_sptx_serial_in (
    .i_clk(clk), .i_reset_n(rst_n), .i_sclk(sclk), .i_fsync(fsync), .i_sdata(sdata),
    .i_cfg_we(cfg_we), .i_cfg_fmt(cfg_fmt), .i_cfg_width(cfg_width), .i_ready(ready),
    .o_valid(valid), .o_data(data), .o_right(right), .o_overflow(ovf)
  );
  sptx_serial_src u_sptx_serial_src (.o_sclk(sclk), .o_fsync(fsync), .o_sdata(sdata));

  // 200 MHz system clock
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  // Overflow pulses counted as they happen, since each lasts one cycle
  always @(posedge clk) begin
    if (ovf === 1'b1) ovf_seen++;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [24:0] got, input logic [24:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Word as seen at the output: MSB-aligned in 24 bits, low bits zero
  function automatic logic [23:0] expd(input logic [1:0] wc, input logic [23:0] word);
    int w;
    w = (wc == 2'h3) ? 24 : 16 + 2 * wc;
    return word << (24 - w);
  endfunction

  // Wait bounded for a head word, compare, then pop it
  task automatic get_word(input logic r, input logic [23:0] d);
    int k;
    k = 0;
    @(posedge clk);
    #1;
    while (valid !== 1'b1 && k < 400) begin
      @(posedge clk);
      #1;
      k++;
    end
    // A wait that runs out shows up as a missing word
    check({24'h00_0000, valid}, 25'h1);
    check({right, data}, {r, d});
    ready = 1'b1;
    @(posedge clk);
    #1 ready = 1'b0;
  endtask

  // Config takes effect two link edges later, so give the link a few idle clocks
  task automatic cfg(input logic [1:0] f, input logic [1:0] w);
    @(posedge clk);
    #1;
    cfg_fmt = f;
    cfg_width = w;
    cfg_we = 1'b1;
    @(posedge clk);
    #1 cfg_we = 1'b0;
    u_sptx_serial_src.idle(4);
  endtask

  // Sync high half first, then low half; the high half may be cut short
  task automatic send(input logic [1:0] f, input logic [1:0] wc, input logic [23:0] hi,
                      input logic [23:0] lo, input int n_hi);
    int w;
    w = (wc == 2'h3) ? 24 : 16 + 2 * wc;
    u_sptx_serial_src.half(1'b1, f, w, hi, n_hi);
    u_sptx_serial_src.half(1'b0, f, w, lo, 32);
  endtask

  // Reset long enough for both domains; the link needs three edges inside it
  task automatic do_reset;
    @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (3) @(posedge clk);
    u_sptx_serial_src.idle(4);
    check({24'h00_0000, valid}, 25'h0);
    @(posedge clk);
    #1 rst_n = 1'b1;
  endtask

  initial begin
    logic i2s;
    rst_n = 1'b0;
    cfg_we = 1'b0;
    cfg_fmt = 2'h0;
    cfg_width = 2'h0;
    ready = 1'b0;
    do_reset();
    $display("reset test done");
    // Table rows; I2S puts the right word under high sync, the others the left
    for (int i = 0; i < 7; i++) begin
      cfg(rows[i].fmt, rows[i].wc);
      send(rows[i].fmt, rows[i].wc, rows[i].hi, rows[i].lo, 32);
      i2s = (rows[i].fmt == 2'h0 || rows[i].fmt == 2'h3);
      get_word(i2s, expd(rows[i].wc, rows[i].hi));
      get_word(~i2s, expd(rows[i].wc, rows[i].lo));
      $display("row %0d done", i);
    end
    // Second reset, then I2S 24-bit stream with no config write
    do_reset();
    u_sptx_serial_src.idle(4);
    send(2'h0, 2'h3, 24'h96_1e2d, 24'h2d_e169, 32);
    get_word(1'b1, 24'h96_1e2d);
    get_word(1'b0, 24'h2d_e169);
    $display("default format test done");
    // Cut-short half frame never reaches the LSB and must give no word
    cfg(2'h2, 2'h3);
    send(2'h2, 2'h3, 24'h55_aa55, 24'h3c_c3a5, 20);
    get_word(1'b1, 24'h3c_c3a5);
    repeat (20) @(posedge clk);
    check({24'h00_0000, valid}, 25'h0);
    $display("short half test done");
    // Fill past 32 plus staging: one overflow, newest word kept
    cfg(2'h1, 2'h0);
    for (int k = 0; k < 17; k++) begin
      send(2'h1, 2'h0, 24'h00_1000 + 2 * k, 24'h00_1001 + 2 * k, 32);
    end
    repeat (20) @(posedge clk);
    check(25'(ovf_seen), 25'h1);
    for (int k = 0; k < 32; k++) begin
      get_word(1'(k % 2), expd(2'h0, 24'h00_1000 + k));
    end
    get_word(1'b1, expd(2'h0, 24'h00_1021));
    repeat (5) @(posedge clk);
    check({24'h00_0000, valid}, 25'h0);
    $display("overflow test done");
    print_verdict();
  end

  // Watchdog well beyond the expected run of about 140 us
  initial begin
    #400_000;
    fail_count++;
    print_verdict();
  end
endmodule // sptx_serial_in_tb
